// ==== design/dcc_defines.vh ====
// Constants of the completion-chaining DMA block: parameter set layout,
// option field positions, reset values and the control register map.
// Assumes it is included by bare name from each design file that uses it.
`ifndef DCC_DEFINES_VH
`define DCC_DEFINES_VH
// Byte offsets of the eight words of one parameter set
`define DCC_OFS_OPTIONS     5'h00
`define DCC_OFS_SRC_ADDR    5'h04
`define DCC_OFS_COUNTS      5'h08
`define DCC_OFS_DST_ADDR    5'h0C
`define DCC_OFS_FRAME_IDX   5'h10
`define DCC_OFS_LINK_RLD    5'h14
`define DCC_OFS_BLOCK_IDX   5'h18
`define DCC_OFS_BLOCK_CNT   5'h1C
`define DCC_SET_BYTES       32
// Options word fields
`define DCC_OPT_PRIV_HI     27
`define DCC_OPT_PRIV_LO     24
`define DCC_OPT_MID_CHAIN   23
`define DCC_OPT_FINAL_CHAIN 22
`define DCC_OPT_MID_IRQ     21
`define DCC_OPT_FINAL_IRQ   20
`define DCC_OPT_CODE_HI     17
`define DCC_OPT_CODE_LO     12
`define DCC_OPT_MODE        11
`define DCC_OPT_FIFOW_HI    10
`define DCC_OPT_FIFOW_LO    8
`define DCC_OPT_STATIC      3
`define DCC_OPT_SYNC_DIMENSION     2
`define DCC_OPT_DAM         1
`define DCC_OPT_SAM         0
`define DCC_OPT_RST         32'h00000000
`define DCC_OPT_WMASK       32'h00F3FF0F
// Count fields: frame count and reload in the high half
`define DCC_CNT_HI          31
`define DCC_CNT_LO          16
`define DCC_BLK_HI          15
`define DCC_BLK_LO          0
// Control registers
`define DCC_REG_CHAIN       12'h400
`define DCC_REG_CHAIN_CLR   12'h404
`define DCC_REG_EVT_SET     12'h408
`define DCC_REG_EVT_FLAGS   12'h40C
`define DCC_REG_IRQ_PEND    12'h410
`define DCC_REG_IRQ_CLR     12'h414
`define DCC_REG_IRQ_EN      12'h418
`define DCC_IRQ_EN_RST      32'h00000000
`define DCC_RESP_OKAY       2'h0
`define DCC_RESP_SLVERR     2'h2
`endif

// ==== design/dcc_flags.v ====
// Bank of sticky flags, one per channel.
// Assumes set and clear pulses come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module dcc_flags #(
  parameter W = 32
) (
  input  wire         i_ref_clk,
  input  wire         i_rst,
  input  wire [W-1:0] i_set,
  input  wire [W-1:0] i_clr,
  output wire [W-1:0] o_flags
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg flag_ff;
      // A set in the same cycle as a clear sets the flag
      always @(posedge i_ref_clk) begin
        if (i_rst) begin
          flag_ff <= 1'b0;
        end else begin
          flag_ff <= i_set[g] | (flag_ff & ~i_clr[g]);
        end
      end
      assign o_flags[g] = flag_ff;
    end
  endgenerate
endmodule // dcc_flags
`default_nettype wire

// ==== design/dcc_parameter_memory_mem.v ====
// Parameter memory: eight words per channel set, two registered reads.
// Assumes one writer per cycle, arbitrated by the caller.
`timescale 1ns/100ps
`default_nettype none
`include "dcc_defines.vh"
module dcc_parameter_memory_mem #(
  parameter NSET = 32,
  parameter IW   = 8
) (
  input  wire          i_ref_clk,
  input  wire          i_rst,
  input  wire          i_wr_en,
  input  wire [IW-1:0] i_wr_idx,
  input  wire [31:0]   i_wr_data,
  input  wire [3:0]    i_wr_strb,
  input  wire          i_priv_upd,
  input  wire [3:0]    i_priv_id,
  input  wire [IW-1:0] i_rd_a_idx,
  input  wire [IW-1:0] i_rd_b_idx,
  output reg  [31:0]   o_rd_a,
  output reg  [31:0]   o_rd_b
);
  reg  [31:0]     word_mem [0:NSET*8-1];
  reg  [31:0]     opt_mem  [0:NSET-1];
  reg  [NSET-1:0] valid_ff;
  wire [IW-4:0]   wr_set = i_wr_idx[IW-1:3];
  wire [31:0]     bmask  = {{8{i_wr_strb[3]}}, {8{i_wr_strb[2]}},
                            {8{i_wr_strb[1]}}, {8{i_wr_strb[0]}}};
  wire [31:0]     old_opt = valid_ff[wr_set] ? opt_mem[wr_set] :
                            `DCC_OPT_RST;
  wire [31:0]     priv_w  = {4'h0, i_priv_id, 24'h000000};
  wire [31:0]     new_opt = ((i_wr_data & bmask) | (old_opt & ~bmask))
                            & `DCC_OPT_WMASK;
  wire [31:0]     opt_keep = old_opt & ~(32'h0F000000);

  // Options of a never written set read as zero without clearing RAM
  function [31:0] rd_word;
    input [IW-1:0] idx;
    begin
      if (idx[2:0] == 3'h0) begin
        rd_word = valid_ff[idx[IW-1:3]] ? opt_mem[idx[IW-1:3]] :
                  `DCC_OPT_RST;
      end else begin
        rd_word = word_mem[idx];
      end
    end
  endfunction

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      valid_ff <= {NSET{1'b0}};
    end else if (i_wr_en) begin
      valid_ff[wr_set] <= 1'b1;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      if (i_wr_idx[2:0] == 3'h0) begin
        opt_mem[wr_set] <= i_priv_upd ? (new_opt | priv_w) :
                           (new_opt | (old_opt & 32'h0F000000));
      end else begin
        word_mem[i_wr_idx] <= (i_wr_data & bmask) |
                              (word_mem[i_wr_idx] & ~bmask);
        if (i_priv_upd) begin
          opt_mem[wr_set] <= opt_keep | priv_w;
        end
      end
    end
    o_rd_a <= rd_word(i_rd_a_idx);
    o_rd_b <= rd_word(i_rd_b_idx);
  end
endmodule // dcc_parameter_memory_mem
`default_nettype wire

// ==== design/dcc_top.v ====
// DMA channel completion and chaining controller with AXI4-Lite slave.
// Assumes an AXI4-Lite master on i_ref_clk and asynchronous event pins.
`timescale 1ns/100ps
`default_nettype none
`include "dcc_defines.vh"
module dcc_top #(
  parameter NCH = 32,
  parameter AW  = 12
) (
  input  wire           i_ref_clk,
  input  wire           i_rst,
  input  wire [AW-1:0]  i_awaddr,
  input  wire           i_awvalid,
  output wire           o_awready,
  input  wire [31:0]    i_wdata,
  input  wire [3:0]     i_wstrb,
  input  wire           i_wvalid,
  output wire           o_wready,
  output wire [1:0]     o_bresp,
  output wire           o_bvalid,
  input  wire           i_bready,
  input  wire [AW-1:0]  i_araddr,
  input  wire           i_arvalid,
  output wire           o_arready,
  output wire [31:0]    o_rdata,
  output wire [1:0]     o_rresp,
  output wire           o_rvalid,
  input  wire           i_rready,
  input  wire [3:0]     i_wr_priv_id,
  input  wire [NCH-1:0] i_event,
  output wire           o_irq,
  output wire           o_array_done,
  output wire [5:0]     o_array_chan,
  output wire           o_array_final,
  output wire           o_busy
);
  localparam SW = 5;
  localparam IW = SW + 3;
  localparam [AW-1:0] PMEM_END = NCH * `DCC_SET_BYTES;
  localparam [4:0] WD_OPT = `DCC_OFS_OPTIONS >> 2;
  localparam [4:0] WD_CNT = `DCC_OFS_COUNTS >> 2;
  localparam [4:0] WD_RLD = `DCC_OFS_LINK_RLD >> 2;
  localparam [4:0] WD_BLK = `DCC_OFS_BLOCK_CNT >> 2;
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_OPT   = 3'h1;
  localparam [2:0] ST_CNT   = 3'h2;
  localparam [2:0] ST_RLD   = 3'h3;
  localparam [2:0] ST_BLK   = 3'h4;
  localparam [2:0] ST_WCNT  = 3'h5;
  localparam [2:0] ST_WBLK  = 3'h6;
  localparam [2:0] ST_DONE  = 3'h7;

  // Event pins cross into the clock domain first
  reg  [NCH-1:0] ev_meta_ff;
  reg  [NCH-1:0] ev_sync_ff;
  reg  [NCH-1:0] ev_prev_ff;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      ev_meta_ff <= {NCH{1'b0}};
      ev_sync_ff <= {NCH{1'b0}};
      ev_prev_ff <= {NCH{1'b0}};
    end else begin
      ev_meta_ff <= i_event;
      ev_sync_ff <= ev_meta_ff;
      ev_prev_ff <= ev_sync_ff;
    end
  end
  wire [NCH-1:0] ev_rise = ev_sync_ff & ~ev_prev_ff;

  // Write channel holding registers
  reg            aw_held_ff;
  reg  [AW-1:0]  awaddr_ff;
  reg            w_held_ff;
  reg  [31:0]    wdata_ff;
  reg  [3:0]     wstrb_ff;
  reg            bvalid_ff;
  reg  [1:0]     bresp_ff;
  reg  [1:0]     nxt_bresp;
  reg  [2:0]     state_ff;
  wire           eng_wr = (state_ff == ST_WCNT) || (state_ff == ST_WBLK);
  wire           do_wr  = aw_held_ff & w_held_ff & ~bvalid_ff & ~eng_wr;
  wire           wr_mem = awaddr_ff < PMEM_END;
  wire [31:0]    wmask  = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                           {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [31:0]    wval   = wdata_ff & wmask;
  wire           wr_reg = do_wr & ~wr_mem;

  assign o_awready = ~aw_held_ff;
  assign o_wready  = ~w_held_ff;
  assign o_bvalid  = bvalid_ff;
  assign o_bresp   = bresp_ff;

  always @* begin
    case (awaddr_ff)
      `DCC_REG_CHAIN_CLR,
      `DCC_REG_EVT_SET,
      `DCC_REG_IRQ_CLR,
      `DCC_REG_IRQ_EN: nxt_bresp = `DCC_RESP_OKAY;
      default:         nxt_bresp = wr_mem ? `DCC_RESP_OKAY :
                                            `DCC_RESP_SLVERR;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= {AW{1'b0}};
      w_held_ff  <= 1'b0;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `DCC_RESP_OKAY;
    end else begin
      if (i_awvalid && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= i_awaddr;
      end
      if (i_wvalid && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= i_wdata;
        wstrb_ff  <= i_wstrb;
      end
      if (do_wr) begin
        bvalid_ff  <= 1'b1;
        bresp_ff   <= nxt_bresp;
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
      end else if (bvalid_ff && i_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Control registers and flag banks
  reg  [31:0]    irq_en_ff;
  wire [NCH-1:0] chain_flags;
  wire [NCH-1:0] evt_flags;
  wire [NCH-1:0] pend_flags;
  reg  [NCH-1:0] chain_set;
  reg  [NCH-1:0] pend_set;
  reg  [NCH-1:0] svc_chain_clr;
  reg  [NCH-1:0] svc_evt_clr;
  wire           wr_chain_clr = wr_reg && awaddr_ff == `DCC_REG_CHAIN_CLR;
  wire           wr_evt_set   = wr_reg && awaddr_ff == `DCC_REG_EVT_SET;
  wire           wr_irq_clr   = wr_reg && awaddr_ff == `DCC_REG_IRQ_CLR;

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq_en_ff <= `DCC_IRQ_EN_RST;
    end else if (wr_reg && awaddr_ff == `DCC_REG_IRQ_EN) begin
      irq_en_ff <= wval | (irq_en_ff & ~wmask);
    end
  end

  dcc_flags #(.W(NCH)) u_chain (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_set     (chain_set),
    .i_clr     (svc_chain_clr | (wr_chain_clr ? wval[NCH-1:0] :
                                 {NCH{1'b0}})),
    .o_flags   (chain_flags)
  );

  dcc_flags #(.W(NCH)) u_event (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_set     (ev_rise | (wr_evt_set ? wval[NCH-1:0] :
                           {NCH{1'b0}})),
    .i_clr     (svc_evt_clr),
    .o_flags   (evt_flags)
  );

  dcc_flags #(.W(NCH)) u_pend (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_set     (pend_set),
    .i_clr     (wr_irq_clr ? wval[NCH-1:0] : {NCH{1'b0}}),
    .o_flags   (pend_flags)
  );

  assign o_irq = |(pend_flags & irq_en_ff[NCH-1:0]);

  // Engine: one sync event moves one array of one channel
  reg  [SW-1:0]  chan_ff;
  reg  [31:0]    opt_ff;
  reg  [31:0]    cnt_ff;
  reg  [31:0]    rld_ff;
  reg  [31:0]    blk_ff;
  reg  [15:0]    nbcnt_ff;
  reg  [15:0]    nccnt_ff;
  reg            final_ff;
  reg            done_ff;
  reg  [2:0]     nxt_state;
  reg  [2:0]     rd_word;
  reg            pick_ok;
  reg  [SW-1:0]  pick;
  integer        k;
  wire [NCH-1:0] sync_req = evt_flags | chain_flags;
  wire [31:0]    mem_a;
  wire [31:0]    mem_b;

  always @* begin
    pick_ok = 1'b0;
    pick    = {SW{1'b0}};
    for (k = NCH - 1; k >= 0; k = k - 1) begin
      if (sync_req[k]) begin
        pick_ok = 1'b1;
        pick    = k[SW-1:0];
      end
    end
  end

  always @* begin
    svc_chain_clr = {NCH{1'b0}};
    svc_evt_clr   = {NCH{1'b0}};
    if (state_ff == ST_IDLE && pick_ok) begin
      // On the picked (lowest) channel, a chained event is served before a pin or software event
      if (chain_flags[pick]) begin
        svc_chain_clr[pick] = 1'b1;
      end else begin
        svc_evt_clr[pick] = 1'b1;
      end
    end
  end

  always @* begin
    case (state_ff)
      ST_IDLE: rd_word = WD_OPT[2:0];
      ST_OPT:  rd_word = WD_CNT[2:0];
      ST_CNT:  rd_word = WD_RLD[2:0];
      ST_RLD:  rd_word = WD_BLK[2:0];
      default: rd_word = WD_OPT[2:0];
    endcase
  end
  wire [SW-1:0] rd_chan = (state_ff == ST_IDLE) ? pick : chan_ff;

  wire [15:0] bcnt  = cnt_ff[`DCC_CNT_HI:`DCC_CNT_LO];
  wire [15:0] block_count  = mem_b[`DCC_BLK_HI:`DCC_BLK_LO];
  wire [15:0] bdec  = bcnt - 16'h0001;
  wire [15:0] cdec  = block_count - 16'h0001;
  wire        syncd = opt_ff[`DCC_OPT_SYNC_DIMENSION];

  always @* begin
    case (state_ff)
      ST_IDLE: nxt_state = pick_ok ? ST_OPT : ST_IDLE;
      ST_OPT:  nxt_state = ST_CNT;
      ST_CNT:  nxt_state = ST_RLD;
      ST_RLD:  nxt_state = ST_BLK;
      ST_BLK:  nxt_state = opt_ff[`DCC_OPT_STATIC] ? ST_DONE : ST_WCNT;
      ST_WCNT: nxt_state = ST_WBLK;
      ST_WBLK: nxt_state = ST_DONE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
      chan_ff  <= {SW{1'b0}};
      opt_ff   <= `DCC_OPT_RST;
      cnt_ff   <= 32'h00000000;
      rld_ff   <= 32'h00000000;
      blk_ff   <= 32'h00000000;
      nbcnt_ff <= 16'h0000;
      nccnt_ff <= 16'h0000;
      final_ff <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      done_ff  <= (state_ff == ST_DONE);
      if (state_ff == ST_IDLE) begin
        chan_ff <= pick;
      end
      if (state_ff == ST_OPT) begin
        opt_ff <= mem_b;
      end
      if (state_ff == ST_CNT) begin
        cnt_ff <= mem_b;
      end
      if (state_ff == ST_RLD) begin
        rld_ff <= mem_b;
      end
      if (state_ff == ST_BLK) begin
        blk_ff <= mem_b;
        if (bcnt == 16'h0000 || block_count == 16'h0000) begin
          nbcnt_ff <= 16'h0000;
          nccnt_ff <= 16'h0000;
          final_ff <= 1'b1;
        end else if (!syncd && bcnt > 16'h0001) begin
          nbcnt_ff <= bdec;
          nccnt_ff <= block_count;
          final_ff <= 1'b0;
        end else if (block_count > 16'h0001) begin
          nbcnt_ff <= rld_ff[`DCC_CNT_HI:`DCC_CNT_LO];
          nccnt_ff <= cdec;
          final_ff <= 1'b0;
        end else begin
          // Last array: counts exhausted, block complete
          nbcnt_ff <= 16'h0000;
          nccnt_ff <= 16'h0000;
          final_ff <= 1'b1;
        end
      end
    end
  end

  // Completion code picks one flag; codes of NCH and above touch nothing
  wire [5:0]     code    = opt_ff[`DCC_OPT_CODE_HI:`DCC_OPT_CODE_LO];
  wire           code_ok = {26'h0, code} < NCH;
  wire [NCH-1:0] code_hot = code_ok ? ({{(NCH-1){1'b0}}, 1'b1} <<
                                        code[SW-1:0]) : {NCH{1'b0}};
  wire           in_done = (state_ff == ST_DONE);
  wire           chain_on = final_ff ? opt_ff[`DCC_OPT_FINAL_CHAIN] :
                                       opt_ff[`DCC_OPT_MID_CHAIN];
  wire           irq_on   = final_ff ? opt_ff[`DCC_OPT_FINAL_IRQ] :
                                       opt_ff[`DCC_OPT_MID_IRQ];

  always @* begin
    chain_set = (in_done && chain_on) ? code_hot : {NCH{1'b0}};
    pend_set  = (in_done && irq_on) ? code_hot : {NCH{1'b0}};
  end

  reg  [5:0] arr_chan_ff;
  reg        arr_final_ff;
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      arr_chan_ff  <= 6'h00;
      arr_final_ff <= 1'b0;
    end else if (in_done) begin
      arr_chan_ff  <= {1'b0, chan_ff};
      arr_final_ff <= final_ff;
    end
  end
  assign o_array_done  = done_ff;
  assign o_array_chan  = arr_chan_ff;
  assign o_array_final = arr_final_ff;
  assign o_busy        = (state_ff != ST_IDLE);

  // Parameter memory: engine write-back has priority over the bus
  wire [IW-1:0] eng_idx = {chan_ff, (state_ff == ST_WCNT) ?
                           WD_CNT[2:0] : WD_BLK[2:0]};
  wire [31:0]   eng_data = (state_ff == ST_WCNT) ?
                           {nbcnt_ff, cnt_ff[15:0]} :
                           {blk_ff[31:16], nccnt_ff};

  dcc_parameter_memory_mem #(.NSET(NCH), .IW(IW)) u_mem (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_wr_en    (eng_wr | (do_wr & wr_mem)),
    .i_wr_idx   (eng_wr ? eng_idx : awaddr_ff[IW+1:2]),
    .i_wr_data  (eng_wr ? eng_data : wdata_ff),
    .i_wr_strb  (eng_wr ? 4'hF : wstrb_ff),
    .i_priv_upd (~eng_wr),
    .i_priv_id  (i_wr_priv_id),
    .i_rd_a_idx (i_araddr[IW+1:2]),
    .i_rd_b_idx ({rd_chan, rd_word}),
    .o_rd_a     (mem_a),
    .o_rd_b     (mem_b)
  );

  // Read channel: one cycle for the registered memory read
  reg            rd_pend_ff;
  reg  [AW-1:0]  araddr_ff;
  reg            rvalid_ff;
  reg  [31:0]    rdata_ff;
  reg  [1:0]     rresp_ff;
  reg  [31:0]    nxt_rdata;
  reg  [1:0]     nxt_rresp;
  wire           ar_take = i_arvalid & ~rd_pend_ff & ~rvalid_ff;
  assign o_arready = ~rd_pend_ff & ~rvalid_ff;
  assign o_rvalid  = rvalid_ff;
  assign o_rdata   = rdata_ff;
  assign o_rresp   = rresp_ff;

  always @* begin
    nxt_rresp = `DCC_RESP_OKAY;
    case (araddr_ff)
      `DCC_REG_CHAIN:     nxt_rdata = {{(32-NCH){1'b0}}, chain_flags};
      `DCC_REG_EVT_FLAGS: nxt_rdata = {{(32-NCH){1'b0}}, evt_flags};
      `DCC_REG_IRQ_PEND:  nxt_rdata = {{(32-NCH){1'b0}}, pend_flags};
      `DCC_REG_IRQ_EN:    nxt_rdata = irq_en_ff;
      `DCC_REG_CHAIN_CLR,
      `DCC_REG_EVT_SET,
      `DCC_REG_IRQ_CLR:   nxt_rdata = 32'h00000000;
      default: begin
        nxt_rdata = (araddr_ff < PMEM_END) ? mem_a : 32'h00000000;
        nxt_rresp = (araddr_ff < PMEM_END) ? `DCC_RESP_OKAY :
                                             `DCC_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rd_pend_ff <= 1'b0;
      araddr_ff  <= {AW{1'b0}};
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= `DCC_RESP_OKAY;
    end else begin
      if (ar_take) begin
        rd_pend_ff <= 1'b1;
        araddr_ff  <= i_araddr;
      end else if (rd_pend_ff) begin
        rd_pend_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= nxt_rdata;
        rresp_ff   <= nxt_rresp;
      end else if (rvalid_ff && i_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
endmodule // dcc_top
`default_nettype wire

// ==== design/dcc_top_fix_note.v ====
// Holds no logic: the controller is dcc_top with its flag bank and
// parameter memory.
// Assumes nothing of its surroundings.

// ==== test/dcc_event_source.sv ====
// Peripheral model that raises a sync event on one pin per request.
// Assumes requests arrive from the bench on i_ref_clk.
`timescale 1ns/100ps
`default_nettype none
module dcc_event_source #(
  parameter NCH = 32
) (
  input  wire logic           i_ref_clk,
  input  wire logic           i_fire,
  input  wire logic [5:0]     i_chan,
  output var  logic [NCH-1:0] o_event
);
  logic [2:0] hold_ff;
  initial begin
    o_event = {NCH{1'b0}};
    hold_ff = 3'h0;
  end
  // Pin held several cycles so the two-stage synchroniser cannot miss it
  always @(posedge i_ref_clk) begin
    if (i_fire) begin
      o_event <= {{(NCH-1){1'b0}}, 1'b1} << i_chan;
      hold_ff <= 3'h4;
    end else if (hold_ff != 3'h0) begin
      hold_ff <= hold_ff - 3'h1;
    end else begin
      o_event <= {NCH{1'b0}};
    end
  end
endmodule // dcc_event_source
`default_nettype wire

// ==== test/dcc_top_asserts.sv ====
// Checker of bus handshakes and completion outputs of the controller.
// Assumes it is bound into dcc_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module dcc_top_asserts #(
  parameter NCH = 32
) (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic        o_irq,
  input wire logic        o_array_done,
  input wire logic [5:0]  o_array_chan
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_take;
    i_arvalid && o_arready;
  endsequence
  // Engine write-back may hold a bus write for two extra cycles
  a_wr_answer: assert property (s_wr_take |-> ##[2:4] o_bvalid)
    else $error("write response missing");
  a_wr_blocked: assert property (s_wr_take |=> !o_awready && !o_wready)
    else $error("write channel ready while busy");
  a_rd_answer: assert property (s_rd_take |-> ##[1:3] o_rvalid)
    else $error("read response missing");
  a_b_hold: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  a_err_zero: assert property (o_rvalid && o_rresp == 2'h2 |->
    o_rdata == 32'h0)
    else $error("error read carries data");
  a_done_pulse: assert property (o_array_done |=> !o_array_done)
    else $error("array done longer than one cycle");
  a_chan_range: assert property (o_array_done |-> o_array_chan < NCH)
    else $error("serviced channel out of range");
  a_reset_quiet: assert property ($fell(i_rst) |->
    !o_irq && !o_bvalid && o_awready)
    else $error("outputs not idle after reset");
endmodule // dcc_top_asserts
bind dcc_top dcc_top_asserts #(.NCH(NCH)) u_dcc_top_asserts (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
  .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_irq(o_irq), .o_array_done(o_array_done),
  .o_array_chan(o_array_chan));
`default_nettype wire

// ==== test/test_dma_completion_chaining.sv ====
// Self-checking bench for the completion and chaining controller.
// Assumes dcc_top, its checker and the event source are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_dma_completion_chaining;
  logic        i_ref_clk, i_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        fire, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        o_irq, o_array_done, o_array_final, o_busy;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, o_rdata, rd;
  logic [1:0]  o_bresp, o_rresp, rs;
  logic [3:0]  priv;
  logic [5:0]  fchan, o_array_chan;
  wire  [31:0] evt;
  int          mismatches, check_count, cycles, n_done, n_final;

  dcc_top #(.NCH(32), .AW(12)) u_dcc_top (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(rready), .i_wr_priv_id(priv), .i_event(evt), .o_irq(o_irq),
    .o_array_done(o_array_done), .o_array_chan(o_array_chan),
    .o_array_final(o_array_final), .o_busy(o_busy));
  dcc_event_source #(.NCH(32)) u_dcc_event_source (
    .i_ref_clk(i_ref_clk), .i_fire(fire), .i_chan(fchan), .o_event(evt));

  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Ceiling far above the few hundred cycles the scenarios need
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (o_array_done === 1'b1) n_done <= n_done + 1;
    if (o_array_done === 1'b1 && o_array_final === 1'b1)
      n_final <= n_final + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ap, wp;
    @(posedge i_ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ap = 1'b1;
    wp = 1'b1;
    while (ap || wp) begin
      @(posedge i_ref_clk);
      if (ap && o_awready === 1'b1) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && o_wready === 1'b1) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge i_ref_clk); while (o_bvalid !== 1'b1);
    rs = o_bresp;
    bready <= 1'b0;
  endtask

  task automatic rdw(input logic [11:0] a);
    @(posedge i_ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge i_ref_clk); while (o_arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge i_ref_clk); while (o_rvalid !== 1'b1);
    rd = o_rdata;
    rs = o_rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    rdw(a);
    check(rd, exp);
  endtask

  // One frame-count per event; array count fixed, one block
  task automatic cfg(input logic [5:0] ch, input logic [31:0] channel_options,
                     input logic [15:0] frames);
    logic [11:0] b;
    b = {1'b0, ch, 5'h00};
    wr(b, channel_options);
    wr(b + 12'h008, {frames, 16'h0010});
    wr(b + 12'h014, 32'h00000000);
    wr(b + 12'h01C, 32'h00000001);
  endtask

  task automatic wait_done(input int n);
    while (n_done < n) @(posedge i_ref_clk);
    repeat (4) @(posedge i_ref_clk);
  endtask

  task automatic t_reset();
    rc(12'h000, 32'h00000000);
    rc(12'h418, 32'h00000000);
  endtask

  task automatic t_opts();
    priv <= 4'hA;
    wr(12'h0A0, 32'hFFFFFFFF);
    rc(12'h0A0, 32'h0AF3FF0F);
    priv <= 4'h3;
    wr(12'h0A4, 32'h12345678);
    rc(12'h0A0, 32'h03F3FF0F);
    rc(12'h0A4, 32'h12345678);
  endtask

  task automatic t_self();
    int d;
    d = n_done;
    cfg(6'd1, 32'h00901000, 16'h0003);
    wr(12'h418, 32'h00000002);
    check({31'h0, o_irq}, 32'h0);
    wr(12'h408, 32'h00000002);
    wait_done(d + 3);
    check(32'(n_final), 32'h1);
    check({26'h0, o_array_chan}, 32'h1);
    check({31'h0, o_busy}, 32'h0);
    rc(12'h400, 32'h00000000);
    rc(12'h410, 32'h00000002);
    check({31'h0, o_irq}, 32'h1);
    wr(12'h414, 32'h00000002);
    rc(12'h410, 32'h00000000);
    check({31'h0, o_irq}, 32'h0);
    check(32'(n_done - d), 32'h3);
  endtask

  task automatic t_cross();
    int d;
    cfg(6'd2, 32'h00403000, 16'h0001);
    cfg(6'd3, 32'h00204000, 16'h0002);
    d = n_done;
    fchan <= 6'd2;
    fire <= 1'b1;
    @(posedge i_ref_clk);
    fire <= 1'b0;
    wait_done(d + 2);
    check(32'(n_final), 32'h2);
    check({26'h0, o_array_chan}, 32'h3);
    rc(12'h410, 32'h00000010);
    rc(12'h400, 32'h00000000);
    wr(12'h408, 32'h00000008);
    wait_done(d + 3);
    check(32'(n_final), 32'h3);
    rc(12'h410, 32'h00000010);
    wr(12'h414, 32'h00000010);
  endtask

  // Frame sync with two blocks: the reload path, then the final array
  task automatic t_block();
    int d;
    d = n_done;
    cfg(6'd4, 32'h00904004, 16'h0001);
    wr(12'h094, 32'h00010000);
    wr(12'h09C, 32'h00000002);
    wr(12'h408, 32'h00000010);
    wait_done(d + 2);
    check(32'(n_final), 32'h4);
    check({26'h0, o_array_chan}, 32'h4);
    check({31'h0, o_busy}, 32'h0);
    rc(12'h410, 32'h00000010);
    rc(12'h088, 32'h00000010);
    rc(12'h09C, 32'h00000000);
    wr(12'h414, 32'h00000010);
  endtask

  task automatic t_err();
    rc(12'hFFC, 32'h00000000);
    check({30'h0, rs}, 32'h2);
    wr(12'h410, 32'h00000001);
    check({30'h0, rs}, 32'h2);
  endtask

  initial begin
    i_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, fire} = 6'h00;
    {awaddr, araddr, wdata, priv, fchan} = 66'h0;
    {mismatches, check_count, cycles, n_done, n_final} = 160'h0;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_reset();
    t_opts();
    t_self();
    t_cross();
    t_block();
    t_err();
    wrap_up();
  end
endmodule // test_dma_completion_chaining
`default_nettype wire
